/* src/scsp_clock_ctrl.sv */
`timescale 1ns/100ps
module scsp_clock_ctrl
  import scsp_pkg::*;
(
  input  wire logic                 pclk,          // System clock, 50 MHz
  input  wire logic                 presetn,       // Async reset, active low
  input  wire logic                 psel,          // APB select
  input  wire logic                 penable,       // APB access phase
  input  wire logic                 pwrite,        // APB write
  input  wire logic [31:0]          paddr,         // APB byte address
  input  wire logic [31:0]          pwdata,        // APB write data
  output logic      [31:0]          prdata,        // APB read data
  output logic                      pready,        // APB ready
  output logic                      pslverr,       // APB error, unmapped
  input  wire logic                 ccp_unlock,    // Protection window open
  input  wire logic [SCSP_NSRC-1:0] osc_stable,    // Oscillator stable pins
  input  wire logic [SCSP_NSRC-1:0] source_tick,   // One pulse per source cycle
  input  wire logic [7:0]           rtc_src_ticks, // RTC source pulses by code
  output logic      [SCSP_NSRC-1:0] osc_on,        // Oscillator enables
  output logic      [2:0]           sys_clk_sel,   // Active system source
  output logic                      switch_busy,   // Source switch in progress
  output scsp_ticks_t               ticks,         // Derived clock enables
  output logic      [2:0]           rtc_src_sel,   // RTC source select
  output logic                      rtc_tick       // Gated RTC source pulse
);

  // Counter mask for divide by two to the power (code+1)/2
  function automatic logic [8:0] a_mask(input logic [4:0] code);
    logic [8:0] m;
    m = 9'h000;
    if (code != SCSP_A_NODIV) begin
      m = 9'(({9'h000, 1'b1} << ((code + 5'h01) >> 1)) - 10'h001);
    end
    return m;
  endfunction

  // Legal A codes: zero, or odd up to the largest ratio
  function automatic logic a_valid(input logic [4:0] code);
    return (code == SCSP_A_NODIV) || (code[0] && code <= SCSP_A_MAXCODE);
  endfunction

  // One-hot mask of a source code
  function automatic logic [SCSP_NSRC-1:0] src_bit(input logic [2:0] code);
    return {{(SCSP_NSRC-1){1'b0}}, 1'b1} << code;
  endfunction

  // Synchroniser and status
  logic [SCSP_NSRC-1:0] sync1_reg, sync2_reg, sync3_reg, stable_reg;
  logic [SCSP_NSRC-1:0] stable_next;
  logic [SCSP_NSRC-1:0] status_reg, status_next;

  // Control registers
  logic [SCSP_NSRC-1:0] osc_on_reg, osc_on_next;
  logic [2:0]           sel_reg, target_reg;
  scsp_sw_state_t       sw_reg;
  logic [1:0]           sw_cnt_reg;
  logic                 busy_reg;
  logic [4:0]           a_pend_reg, a_act_reg;
  logic [1:0]           bc_pend_reg, bc_act_reg;
  logic                 lock_reg;
  logic [2:0]           rtc_src_reg;
  logic                 rtc_gate_reg;
  logic                 rtc_tick_reg;

  // Prescaler state
  logic [8:0]           a_cnt_reg;
  logic [1:0]           bc_cnt_reg;
  scsp_ticks_t          ticks_reg, ticks_next;

  // APB
  logic [31:0]          prdata_reg, rdata_next;
  logic                 pready_reg, pslverr_reg;

  // Three-flop pin capture; change accepted when stages two and three agree
  assign stable_next = (sync2_reg & sync3_reg) | (stable_reg & (sync2_reg | sync3_reg));
  // Ready flags: synced stable level of an enabled oscillator
  wire base_rc_ready_flag = stable_next[SCSP_SRC_BASE_RC] && osc_on_reg[SCSP_SRC_BASE_RC];
  wire fast_rc_ready_flag = stable_next[SCSP_SRC_FAST_RC] && osc_on_reg[SCSP_SRC_FAST_RC];
  wire slow_rc_ready_flag = stable_next[SCSP_SRC_SLOW_RC] && osc_on_reg[SCSP_SRC_SLOW_RC];
  wire ext_osc_ready_flag = stable_next[SCSP_SRC_EXT] && osc_on_reg[SCSP_SRC_EXT];
  wire pll_ready_flag     = stable_next[SCSP_SRC_PLL] && osc_on_reg[SCSP_SRC_PLL];
  assign status_next = {pll_ready_flag, ext_osc_ready_flag, slow_rc_ready_flag,
                        fast_rc_ready_flag, base_rc_ready_flag};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg  <= '0;
      sync2_reg  <= '0;
      sync3_reg  <= '0;
      stable_reg <= '0;
      status_reg <= '0;
    end else begin
      sync1_reg  <= osc_stable;
      sync2_reg  <= sync1_reg;
      sync3_reg  <= sync2_reg;
      stable_reg <= stable_next;
      status_reg <= status_next;
    end
  end

  // Address decode
  wire [SCSP_ADDR_W-1:0] idx      = paddr[SCSP_IDX_LSB +: SCSP_ADDR_W];
  wire                   aligned  = (paddr[SCSP_IDX_LSB-1:0] == 2'h0) &&
                                    (paddr[31:SCSP_IDX_LSB+SCSP_ADDR_W] == '0);
  wire hit_sel    = aligned && idx == SCSP_IDX_SEL;
  wire hit_status = aligned && idx == SCSP_IDX_STATUS;
  wire hit_presc  = aligned && idx == SCSP_IDX_PRESC;
  wire hit_lock   = aligned && idx == SCSP_IDX_LOCK;
  wire hit_rtc    = aligned && idx == SCSP_IDX_RTC;
  wire hit_oscen  = aligned && idx == SCSP_IDX_OSCEN;
  wire mapped     = hit_sel | hit_status | hit_presc | hit_lock | hit_rtc | hit_oscen;

  wire setup_ph   = psel && !penable;
  wire sw_idle    = (sw_reg == SCSP_SW_IDLE);
  wire wr_go      = psel && penable && pready_reg && pwrite && !pslverr_reg;
  wire prot_ok    = ccp_unlock && !lock_reg;

  // Source selection request
  wire [2:0] sel_req    = pwdata[SCSP_SEL_MSB:0];
  wire       sel_code_ok = sel_req <= SCSP_SRC_PLL;
  wire       sel_rdy    = sel_code_ok && status_reg[sel_req];
  wire       sel_wr     = wr_go && hit_sel && prot_ok && sel_rdy &&
                          (sw_reg == SCSP_SW_IDLE) && (sel_req != sel_reg);

  // Prescale request
  wire [4:0] a_req      = pwdata[SCSP_A_MSB:SCSP_A_LSB];
  wire [1:0] bc_req     = pwdata[SCSP_BC_MSB:0];
  wire       presc_wr   = wr_go && hit_presc && prot_ok && a_valid(a_req);

  wire       lock_set   = wr_go && hit_lock && ccp_unlock && pwdata[SCSP_LOCK_BIT];

  wire [2:0] rtc_req    = pwdata[SCSP_RTC_CLK_SOURCE_MSB:SCSP_RTC_CLK_SOURCE_LSB];
  wire       rtc_ok     = (rtc_req == SCSP_RTC_ULP) || (rtc_req == SCSP_RTC_XTAL) ||
                          (rtc_req == SCSP_RTC_RC) || (rtc_req == SCSP_RTC_XTAL32);
  wire       rtc_wr     = wr_go && hit_rtc;
  wire       rtc_clk_gate = pwdata[SCSP_RTC_CLK_GATE_BIT];

  // Active and switching-to sources may not be switched off
  wire [SCSP_NSRC-1:0] keep_on = src_bit(sel_reg) | (sw_idle ? '0 : src_bit(target_reg));
  // Requested enables; the kept mask wins over a clear
  wire pll_on     = pwdata[SCSP_SRC_PLL];
  wire ext_osc_on = pwdata[SCSP_SRC_EXT];
  wire slow_rc_on = pwdata[SCSP_SRC_SLOW_RC];
  wire fast_rc_on = pwdata[SCSP_SRC_FAST_RC];
  wire base_rc_on = pwdata[SCSP_SRC_BASE_RC];
  wire [SCSP_NSRC-1:0] on_req = {pll_on, ext_osc_on, slow_rc_on, fast_rc_on, base_rc_on};
  assign osc_on_next = (wr_go && hit_oscen) ? (on_req | keep_on) : osc_on_reg;

  // Switch sequencing ticks
  wire old_tick = source_tick[sel_reg];
  wire new_tick = source_tick[target_reg];
  wire sw_last  = (sw_cnt_reg == SCSP_SWITCH_TICKS - 2'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg    <= SCSP_SRC_BASE_RC;
      target_reg <= SCSP_SRC_BASE_RC;
      sw_reg     <= SCSP_SW_IDLE;
      sw_cnt_reg <= 2'h0;
      busy_reg   <= 1'b0;
    end else begin
      case (sw_reg)
        SCSP_SW_IDLE: begin
          if (sel_wr) begin
            target_reg <= sel_req;
            // Busy kept in its own flop so the pin is registered
            busy_reg   <= 1'b1;
            sw_cnt_reg <= 2'h0;
            sw_reg     <= SCSP_SW_OLD;
          end
        end
        SCSP_SW_OLD: begin
          if (old_tick) begin
            sw_cnt_reg <= sw_last ? 2'h0 : sw_cnt_reg + 2'h1;
            if (sw_last) begin
              sel_reg <= target_reg;
              sw_reg  <= SCSP_SW_NEW;
            end
          end
        end
        SCSP_SW_NEW: begin
          if (new_tick) begin
            sw_cnt_reg <= sw_last ? 2'h0 : sw_cnt_reg + 2'h1;
            if (sw_last) begin
              sw_reg   <= SCSP_SW_IDLE;
              busy_reg <= 1'b0;
            end
          end
        end
        default: begin
          sw_reg   <= SCSP_SW_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  // Prescaler chain, driven by the active source while no switch is running
  wire       sys_tick = source_tick[sel_reg] && (sw_reg == SCSP_SW_IDLE);
  wire [8:0] a_m      = a_mask(a_act_reg);
  wire       a_wrap   = (a_cnt_reg & a_m) == a_m;
  wire       x4_hit   = sys_tick && a_wrap;

  // B mask and total B*C mask per code
  wire [1:0] b_m = (bc_act_reg == SCSP_BC_4_1) ? 2'h3 :
                   (bc_act_reg == SCSP_BC_2_2) ? 2'h1 : 2'h0;
  wire [1:0] t_m = (bc_act_reg == SCSP_BC_1_1) ? 2'h0 :
                   (bc_act_reg == SCSP_BC_1_2) ? 2'h1 : 2'h3;
  wire       x2_hit  = x4_hit && ((bc_cnt_reg & b_m) == b_m);
  wire       per_hit = x4_hit && (bc_cnt_reg == t_m);

  assign ticks_next = '{per_x4: x4_hit, per_x2: x2_hit, per: per_hit, cpu: per_hit};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_cnt_reg   <= 9'h000;
      bc_cnt_reg  <= 2'h0;
      a_act_reg   <= SCSP_A_NODIV;
      bc_act_reg  <= SCSP_BC_1_1;
      a_pend_reg  <= SCSP_A_NODIV;
      bc_pend_reg <= SCSP_BC_1_1;
      ticks_reg   <= '0;
    end else begin
      ticks_reg <= ticks_next;
      if (presc_wr) begin
        a_pend_reg  <= a_req;
        bc_pend_reg <= bc_req;
      end
      if (per_hit) begin
        // New factors land on the slowest edge; restart keeps clocks aligned
        a_act_reg  <= a_pend_reg;
        bc_act_reg <= bc_pend_reg;
        a_cnt_reg  <= 9'h000;
        bc_cnt_reg <= 2'h0;
      end else if (sys_tick) begin
        a_cnt_reg <= a_wrap ? 9'h000 : a_cnt_reg + 9'h001;
        if (x4_hit) begin
          bc_cnt_reg <= bc_cnt_reg + 2'h1;
        end
      end
    end
  end

  // Lock, RTC and oscillator enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_reg     <= 1'b0;
      rtc_src_reg  <= SCSP_RTC_ULP;
      rtc_gate_reg <= 1'b0;
      rtc_tick_reg <= 1'b0;
      osc_on_reg   <= SCSP_OSCEN_RST;
    end else begin
      // Lock only ever sets; reset is its sole clear
      if (lock_set) begin
        lock_reg <= 1'b1;
      end
      if (rtc_wr) begin
        // Gate bit lands even when the source code is reserved
        rtc_gate_reg <= rtc_clk_gate;
        if (rtc_ok) begin
          rtc_src_reg <= rtc_req;
        end
      end
      rtc_tick_reg <= rtc_gate_reg && rtc_src_ticks[rtc_src_reg];
      osc_on_reg   <= osc_on_next;
    end
  end

  // Read mux
  // Prescale readback shows the pending value until it lands
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hit_sel) begin
      rdata_next[SCSP_SEL_MSB:0] = sel_reg;
    end else if (hit_status) begin
      rdata_next[SCSP_NSRC-1:0] = status_reg;
    end else if (hit_presc) begin
      rdata_next[SCSP_A_MSB:SCSP_A_LSB] = a_pend_reg;
      rdata_next[SCSP_BC_MSB:0]         = bc_pend_reg;
    end else if (hit_lock) begin
      rdata_next[SCSP_LOCK_BIT] = lock_reg;
    end else if (hit_rtc) begin
      rdata_next[SCSP_RTC_CLK_SOURCE_MSB:SCSP_RTC_CLK_SOURCE_LSB] = rtc_src_reg;
      rdata_next[SCSP_RTC_CLK_GATE_BIT]                  = rtc_gate_reg;
    end else if (hit_oscen) begin
      rdata_next[SCSP_NSRC-1:0] = osc_on_reg;
    end
  end

  // One wait-free access: answer prepared in setup, ready in first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup_ph;
      pslverr_reg <= setup_ph && !mapped;
      if (setup_ph && !pwrite) begin
        prdata_reg <= rdata_next;
      end
    end
  end

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign osc_on      = osc_on_reg;
  assign sys_clk_sel = sel_reg;
  assign switch_busy = busy_reg;
  assign ticks       = ticks_reg;
  assign rtc_src_sel = rtc_src_reg;
  assign rtc_tick    = rtc_tick_reg;

endmodule

/* src/scsp_pkg.sv */
package scsp_pkg;

  // Register indices; byte address is index times four
  localparam logic [7:0] SCSP_IDX_SEL    = 8'h00;
  localparam logic [7:0] SCSP_IDX_STATUS = 8'h01;
  localparam logic [7:0] SCSP_IDX_PRESC  = 8'h02;
  localparam logic [7:0] SCSP_IDX_LOCK   = 8'h03;
  localparam logic [7:0] SCSP_IDX_RTC    = 8'h04;
  localparam logic [7:0] SCSP_IDX_OSCEN  = 8'h05;
  localparam int         SCSP_ADDR_W     = 8;
  localparam int         SCSP_IDX_LSB    = 2;

  // Source codes, shared by select field, enable and status bit positions
  localparam logic [2:0] SCSP_SRC_BASE_RC = 3'h0;
  localparam logic [2:0] SCSP_SRC_FAST_RC = 3'h1;
  localparam logic [2:0] SCSP_SRC_SLOW_RC = 3'h2;
  localparam logic [2:0] SCSP_SRC_EXT     = 3'h3;
  localparam logic [2:0] SCSP_SRC_PLL     = 3'h4;
  localparam int         SCSP_NSRC        = 5;

  // Field layout
  localparam int SCSP_SEL_MSB   = 2;
  localparam int SCSP_A_MSB     = 6;
  localparam int SCSP_A_LSB     = 2;
  localparam int SCSP_BC_MSB    = 1;
  localparam int SCSP_LOCK_BIT  = 0;
  localparam int SCSP_RTC_CLK_SOURCE_MSB = 3;
  localparam int SCSP_RTC_CLK_SOURCE_LSB = 1;
  localparam int SCSP_RTC_CLK_GATE_BIT = 0;

  // Codes
  localparam logic [4:0] SCSP_A_NODIV   = 5'h00;
  localparam logic [4:0] SCSP_A_MAXCODE = 5'h11;
  localparam logic [1:0] SCSP_BC_1_1    = 2'h0;
  localparam logic [1:0] SCSP_BC_1_2    = 2'h1;
  localparam logic [1:0] SCSP_BC_4_1    = 2'h2;
  localparam logic [1:0] SCSP_BC_2_2    = 2'h3;
  localparam logic [2:0] SCSP_RTC_ULP   = 3'h0;
  localparam logic [2:0] SCSP_RTC_XTAL  = 3'h1;
  localparam logic [2:0] SCSP_RTC_RC    = 3'h2;
  localparam logic [2:0] SCSP_RTC_XTAL32 = 3'h5;

  // Reset values
  localparam logic [4:0] SCSP_OSCEN_RST = 5'h01;
  localparam logic [7:0] SCSP_ZERO8     = 8'h00;

  // Cycles of each source during a switch
  localparam logic [1:0] SCSP_SWITCH_TICKS = 2'h2;

  typedef enum logic [1:0] {
    SCSP_SW_IDLE = 2'b00,
    SCSP_SW_OLD  = 2'b01,
    SCSP_SW_NEW  = 2'b10
  } scsp_sw_state_t;

  typedef struct packed {
    logic per_x4;
    logic per_x2;
    logic per;
    logic cpu;
  } scsp_ticks_t;

endpackage

/* verification/scsp_clock_ctrl_properties.sv */
`timescale 1ns/100ps
module scsp_clock_ctrl_properties
  import scsp_pkg::*;
(
  input wire logic                 pclk,          // Clock
  input wire logic                 presetn,       // Reset
  input wire logic                 psel,          // Select
  input wire logic                 penable,       // Access
  input wire logic                 pready,        // Ready
  input wire logic [SCSP_NSRC-1:0] source_tick,   // Source pulses
  input wire logic [7:0]           rtc_src_ticks, // RTC pulses
  input wire logic [SCSP_NSRC-1:0] osc_on,        // Enables
  input wire logic [2:0]           sys_clk_sel,   // Active source
  input wire logic                 switch_busy,   // Switching
  input wire scsp_ticks_t          ticks,         // Derived pulses
  input wire logic [2:0]           rtc_src_sel,   // RTC source
  input wire logic                 rtc_tick       // RTC pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       src_q;
  logic       rtc_q;
  logic [2:0] sel_q;
  logic [1:0] n_tk;
  // Ticks of one source seen during a switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= 1'b0;
      rtc_q <= 1'b0;
      sel_q <= 3'h0;
      n_tk  <= 2'h0;
    end else begin
      src_q <= source_tick[sys_clk_sel];
      rtc_q <= rtc_src_ticks[rtc_src_sel];
      sel_q <= sys_clk_sel;
      if (!switch_busy) n_tk <= 2'h0;
      else if (sys_clk_sel != sel_q) n_tk <= {1'b0, source_tick[sys_clk_sel]};
      else if (source_tick[sys_clk_sel] && n_tk != 2'h3) n_tk <= n_tk + 2'h1;
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  property p_apb_ready; s_setup |=> s_answer; endproperty
  property p_sel_legal; sys_clk_sel <= 3'h4; endproperty
  property p_active_on; osc_on[sys_clk_sel]; endproperty
  property p_sel_busy; $changed(sys_clk_sel) |-> switch_busy; endproperty
  property p_tick_cnt; n_tk != 2'h3; endproperty
  property p_quiet; switch_busy && $past(switch_busy) |-> ticks == 4'h0; endproperty
  property p_x4_cause; ticks.per_x4 |-> src_q; endproperty
  property p_x2_in_x4; ticks.per_x2 |-> ticks.per_x4; endproperty
  property p_per_cpu; ticks.per |-> ticks.cpu && ticks.per_x2; endproperty
  property p_rtc; rtc_tick |-> rtc_q; endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("pready not one cycle after setup");
  a_sel_legal: assert property (p_sel_legal) else $error("reserved source active");
  a_active_on: assert property (p_active_on) else $error("active source disabled");
  a_sel_busy: assert property (p_sel_busy) else $error("source changed outside switch");
  a_tick_cnt: assert property (p_tick_cnt) else $error("switch overran two ticks");
  a_quiet: assert property (p_quiet) else $error("derived tick during switch");
  a_x4_cause: assert property (p_x4_cause) else $error("per_x4 without source tick");
  a_x2_in_x4: assert property (p_x2_in_x4) else $error("per_x2 out of phase");
  a_per_cpu: assert property (p_per_cpu) else $error("per or cpu out of phase");
  a_rtc: assert property (p_rtc) else $error("rtc tick without source");
endmodule

bind scsp_clock_ctrl scsp_clock_ctrl_properties i_props (.pclk, .presetn, .psel, .penable, .pready,
  .source_tick, .rtc_src_ticks, .osc_on, .sys_clk_sel, .switch_busy, .ticks, .rtc_src_sel, .rtc_tick);

/* verification/tb.sv */
`timescale 1ns/100ps
module tb
  import scsp_pkg::*;
;
  logic        pclk          = 1'b0;
  logic        presetn       = 1'b0;
  logic        psel          = 1'b0;
  logic        penable       = 1'b0;
  logic        pwrite        = 1'b0;
  logic [31:0] paddr         = 32'h0;
  logic [31:0] pwdata        = 32'h0;
  logic        ccp_unlock    = 1'b1;
  logic [4:0]  osc_stable    = 5'h00;
  logic [4:0]  source_tick   = 5'h00;
  logic [7:0]  rtc_src_ticks = 8'h00;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  osc_on;
  logic [2:0]  sys_clk_sel;
  logic        switch_busy;
  scsp_ticks_t ticks;
  logic [2:0]  rtc_src_sel;
  logic        rtc_tick;
  logic [31:0] rd;
  logic        err;
  int          errors        = 0;
  int          n_tests       = 0;
  int          gap;
  int          bm [4]        = '{1, 1, 4, 2};
  int          cm [4]        = '{1, 2, 1, 2};
  logic [2:0]  rc [4]        = '{3'h0, 3'h1, 3'h2, 3'h5};

  scsp_clock_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ccp_unlock, .osc_stable, .source_tick, .rtc_src_ticks, .osc_on, .sys_clk_sel,
    .switch_busy, .ticks, .rtc_src_sel, .rtc_tick);

  always #10 pclk = ~pclk;
  // Every source ticks on alternate cycles
  always @(posedge pclk) source_tick <= {5{~source_tick[0]}};

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      errors++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, {24'h0, exp});
  endtask

  // Waits out a switch; reports whether one started
  task automatic settle(input logic exp);
    int n;
    logic saw;
    saw = 1'b0;
    for (n = 0; n < 64; n++) begin
      @(negedge pclk);
      if (switch_busy === 1'b1) saw = 1'b1;
      else if (saw || n > 4) break;
    end
    if (n >= 64) begin
      errors++;
      end_of_test();
    end
    check(32'(saw), 32'(exp));
    @(posedge pclk);
  endtask

  task automatic per_gap(input int b);
    for (int k = 0; k < 2; k++) begin
      gap = 0;
      do begin
        @(negedge pclk);
        gap++;
      end while (ticks[b] !== 1'b1 && gap < 4000);
      if (gap >= 4000) begin
        errors++;
        end_of_test();
      end
    end
    @(posedge pclk);
  endtask

  task automatic pset(input logic [7:0] d);
    apb(1'b1, SCSP_IDX_PRESC, d);
    per_gap(1);
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(SCSP_IDX_SEL, 8'h00);
    rd_chk(SCSP_IDX_STATUS, 8'h00);
    rd_chk(SCSP_IDX_PRESC, 8'h00);
    rd_chk(SCSP_IDX_LOCK, 8'h00);
    rd_chk(SCSP_IDX_RTC, 8'h00);
    rd_chk(SCSP_IDX_OSCEN, 8'h01);
    apb(1'b0, 8'h06, 8'h00);
    check(32'(err), 32'h1);
    $display("test reset done");
    apb(1'b1, SCSP_IDX_OSCEN, 8'h15);
    check(32'(osc_on), 32'h15);
    osc_stable <= 5'h1f;
    repeat (8) @(posedge pclk);
    rd_chk(SCSP_IDX_STATUS, 8'h15);
    apb(1'b1, SCSP_IDX_OSCEN, 8'h1f);
    osc_stable <= 5'h1d;
    repeat (8) @(posedge pclk);
    rd_chk(SCSP_IDX_STATUS, 8'h1d);
    apb(1'b1, SCSP_IDX_STATUS, 8'h00);
    rd_chk(SCSP_IDX_STATUS, 8'h1d);
    $display("test oscillators done");
    apb(1'b1, SCSP_IDX_SEL, 8'h01);
    settle(1'b0);
    osc_stable <= 5'h1f;
    ccp_unlock <= 1'b0;
    repeat (8) @(posedge pclk);
    rd_chk(SCSP_IDX_STATUS, 8'h1f);
    apb(1'b1, SCSP_IDX_SEL, 8'h01);
    settle(1'b0);
    ccp_unlock <= 1'b1;
    apb(1'b1, SCSP_IDX_SEL, 8'h05);
    settle(1'b0);
    for (int i = 1; i <= 5; i++) begin
      apb(1'b1, SCSP_IDX_SEL, 8'(i % 5));
      settle(1'b1);
      check(32'(sys_clk_sel), 32'(i % 5));
      rd_chk(SCSP_IDX_SEL, 8'(i % 5));
    end
    apb(1'b1, SCSP_IDX_OSCEN, 8'h00);
    check(32'(osc_on), 32'h01);
    apb(1'b1, SCSP_IDX_SEL, 8'h02);
    settle(1'b0);
    apb(1'b1, SCSP_IDX_OSCEN, 8'h1f);
    $display("test select done");
    for (int i = 0; i < 4; i++) begin
      pset({3'h0, 3'h1, i[1:0]});
      per_gap(2);
      check(32'(gap), 32'(4 * bm[i]));
      per_gap(1);
      check(32'(gap), 32'(4 * bm[i] * cm[i]));
    end
    apb(1'b1, SCSP_IDX_PRESC, 8'h08);
    rd_chk(SCSP_IDX_PRESC, 8'h07);
    pset(8'h44);
    per_gap(3);
    check(32'(gap), 32'd1024);
    pset(8'h00);
    per_gap(3);
    check(32'(gap), 32'd2);
    $display("test prescale done");
    ccp_unlock <= 1'b0;
    apb(1'b1, SCSP_IDX_LOCK, 8'h01);
    rd_chk(SCSP_IDX_LOCK, 8'h00);
    ccp_unlock <= 1'b1;
    apb(1'b1, SCSP_IDX_LOCK, 8'h01);
    apb(1'b1, SCSP_IDX_LOCK, 8'h00);
    rd_chk(SCSP_IDX_LOCK, 8'h01);
    apb(1'b1, SCSP_IDX_SEL, 8'h01);
    settle(1'b0);
    apb(1'b1, SCSP_IDX_PRESC, 8'h07);
    rd_chk(SCSP_IDX_PRESC, 8'h00);
    $display("test lock done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, SCSP_IDX_RTC, {4'h0, rc[i], 1'b1});
      check(32'(rtc_src_sel), 32'(rc[i]));
      rtc_src_ticks <= 8'h01 << rc[i];
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      check(32'(rtc_tick), 32'h1);
      @(posedge pclk);
      rtc_src_ticks <= ~(8'h01 << rc[i]);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      check(32'(rtc_tick), 32'h0);
    end
    apb(1'b1, SCSP_IDX_RTC, 8'h07);
    check(32'(rtc_src_sel), 32'h5);
    apb(1'b1, SCSP_IDX_RTC, 8'h0a);
    rtc_src_ticks <= 8'hff;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check(32'(rtc_tick), 32'h0);
    $display("test rtc done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(SCSP_IDX_LOCK, 8'h00);
    check(32'(osc_on), 32'h01);
    $display("test second reset done");
    end_of_test();
  end
endmodule
